/* include/mtcr_pkg.sv */
// Package for the meter tamper, cycle and temperature register bank
//
// Function
// [R01] Tamper flagged when active-power difference reaches the tamper threshold.
// [R02] Under tamper, the larger active power feeds pulse accumulation.
// [R03] Tamper threshold is signed fraction, reset 0x828f5c.
// [R04] Computation cycle spans 1024 times N divided-clock samples.
// [R05] Software never writes cycle count below two.
// [R06] Cycle count is unsigned 24-bit, reset 0x000fa0.
// [R07] Two reactive-power results, unsigned fractions, read-only at indices 20, 21.
// [R08] Temperature gain unsigned, seven integer bits, reset 0x34e2e7.
// [R09] Temperature gain scales the temperature result.
// [R10] Temperature offset, signed fraction reset 0xf38701, cancels channel offset.
// [R11] Configuration registers read-write; result registers read-only, writes ignored.
`default_nettype none
package mtcr_pkg;
   localparam int DataW = 24;
   typedef logic [DataW-1:0] mtcr_word_t;
   // Printed offsets are indices; byte address is four times the index
   localparam logic [7:0] IdxTempGain   = 8'h02;
   localparam logic [7:0] IdxTempOffset = 8'h03;
   localparam logic [7:0] IdxTamper     = 8'h12;
   localparam logic [7:0] IdxCycleCount = 8'h13;
   localparam logic [7:0] IdxReactive1  = 8'h14;
   localparam logic [7:0] IdxReactive2  = 8'h15;
   localparam logic [7:0] IdxIrqStatus  = 8'h20;
   localparam logic [7:0] IdxIrqMask    = 8'h21;
   localparam mtcr_word_t RstTempGain   = 24'h34e2e7;
   localparam mtcr_word_t RstTempOffset = 24'hf38701;
   localparam mtcr_word_t RstTamper     = 24'h828f5c;
   localparam mtcr_word_t RstCycleCount = 24'h000fa0;
   localparam int SamplesPerUnit = 1024;
   localparam logic [1:0] RespOkay   = 2'h0;
   localparam logic [1:0] RespSlvErr = 2'h2;
   // Interrupt status bits
   localparam int IrqCycleBit  = 0;
   localparam int IrqTamperBit = 1;
   localparam int IrqW         = 2;
   typedef struct packed {
      mtcr_word_t firstActive;
      mtcr_word_t secondActive;
      mtcr_word_t reactiveFirst;
      mtcr_word_t reactiveSecond;
      mtcr_word_t tempRaw;
      logic       resultValid;
   } mtcr_meas_s;
endpackage : mtcr_pkg
`default_nettype wire

/* src/mtcr_regs.sv */
// Register bank with AXI4-Lite slave, tamper select, cycle timing and temperature scaling
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
module mtcr_regs #(
   parameter int KDiv = 1
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [7:0]          sAxiAwaddr,
   input  wire logic                sAxiAwvalid,
   output logic                     sAxiAwready,
   input  wire logic [31:0]         sAxiWdata,
   input  wire logic [3:0]          sAxiWstrb,
   input  wire logic                sAxiWvalid,
   output logic                     sAxiWready,
   output logic [1:0]               sAxiBresp,
   output logic                     sAxiBvalid,
   input  wire logic                sAxiBready,
   input  wire logic [7:0]          sAxiAraddr,
   input  wire logic                sAxiArvalid,
   output logic                     sAxiArready,
   output logic [31:0]              sAxiRdata,
   output logic [1:0]               sAxiRresp,
   output logic                     sAxiRvalid,
   input  wire logic                sAxiRready,
   input  wire mtcr_pkg::mtcr_meas_s meas,
   output mtcr_pkg::mtcr_word_t     pulsePower,
   output mtcr_pkg::mtcr_word_t     tempResult,
   output logic                     tamperActive,
   output logic                     cycleTick,
   output logic                     irq
);
   import mtcr_pkg::*;

   // Sample divider is 16 bits wide, so larger ratios cannot be served
   if (KDiv < 1 || KDiv > 65536) begin : g_bad_kdiv
      $error("KDiv must lie between one and 65536");
   end

   mtcr_word_t      tempGainQ;
   mtcr_word_t      tempOffsetQ;
   mtcr_word_t      tamperQ;
   mtcr_word_t      cycleCountQ;
   mtcr_word_t      react1Q;
   mtcr_word_t      react2Q;
   logic [IrqW-1:0] irqStatusQ;
   logic [IrqW-1:0] irqMaskQ;
   logic [IrqW-1:0] irqEvent;
   logic [IrqW-1:0] irqClear;

   // Write channel: address and data taken independently, response after both
   logic        awHeldQ;
   logic        wHeldQ;
   logic [7:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0]  wStrbQ;
   logic        doWrite;
   logic [7:0]  wrIdx;
   logic        wrHit;

   assign doWrite = awHeldQ && wHeldQ && !sAxiBvalid;
   assign wrIdx = {2'h0, awAddrQ[7:2]};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHeldQ <= 1'b0;
         wHeldQ  <= 1'b0;
         awAddrQ <= 8'h00;
         wDataQ  <= 32'h0000_0000;
         wStrbQ  <= 4'h0;
      end else begin
         if (sAxiAwvalid && sAxiAwready) begin
            awHeldQ <= 1'b1;
            awAddrQ <= sAxiAwaddr;
         end else if (doWrite) begin
            awHeldQ <= 1'b0;
         end
         if (sAxiWvalid && sAxiWready) begin
            wHeldQ <= 1'b1;
            wDataQ <= sAxiWdata;
            wStrbQ <= sAxiWstrb;
         end else if (doWrite) begin
            wHeldQ <= 1'b0;
         end
      end
   end

   // Ready drops after a handshake, so only one item of each kind is held
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sAxiAwready <= 1'b0;
      end else begin
         sAxiAwready <= !awHeldQ && !(sAxiAwvalid && sAxiAwready);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sAxiWready <= 1'b0;
      end else begin
         sAxiWready <= !wHeldQ && !(sAxiWvalid && sAxiWready);
      end
   end

   always_comb begin
      case (wrIdx)
         IdxTempGain, IdxTempOffset, IdxTamper, IdxCycleCount,
         IdxReactive1, IdxReactive2, IdxIrqStatus, IdxIrqMask: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sAxiBvalid <= 1'b0;
         sAxiBresp  <= RespOkay;
      end else begin
         if (doWrite) begin
            sAxiBvalid <= 1'b1;
            sAxiBresp  <= wrHit ? RespOkay : RespSlvErr;
         end else if (sAxiBready) begin
            sAxiBvalid <= 1'b0;
         end
      end
   end

   // Byte-lane merge for 24-bit registers; lane 3 has no bits
   function automatic mtcr_word_t merge(input mtcr_word_t old, input logic [31:0] d, input logic [3:0] s);
      mtcr_word_t r;
      r = old;
      for (int i = 0; i < 3; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   logic wrGain;
   logic wrOff;
   logic wrTamp;
   logic wrCyc;
   logic wrSts;
   logic wrMsk;
   assign wrGain = doWrite && wrIdx == IdxTempGain;
   assign wrOff  = doWrite && wrIdx == IdxTempOffset;
   assign wrTamp = doWrite && wrIdx == IdxTamper;
   assign wrCyc  = doWrite && wrIdx == IdxCycleCount;
   assign wrSts  = doWrite && wrIdx == IdxIrqStatus && wStrbQ[0];
   assign wrMsk  = doWrite && wrIdx == IdxIrqMask && wStrbQ[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tempGainQ   <= RstTempGain;   // see [R08]
         tempOffsetQ <= RstTempOffset; // see [R10]
         tamperQ     <= RstTamper;     // see [R03]
         cycleCountQ <= RstCycleCount; // see [R06]
      end else begin
         // Result registers take no write path at all, see [R11]
         if (wrGain) begin
            tempGainQ <= merge(tempGainQ, wDataQ, wStrbQ);
         end
         if (wrOff) begin
            tempOffsetQ <= merge(tempOffsetQ, wDataQ, wStrbQ);
         end
         if (wrTamp) begin
            tamperQ <= merge(tamperQ, wDataQ, wStrbQ);
         end
         if (wrCyc) begin
            cycleCountQ <= merge(cycleCountQ, wDataQ, wStrbQ);
         end
      end
   end

   // Divided-clock sample tick, then 1024*N samples per computation cycle
   logic [15:0] kCntQ;
   logic        sampleTick;
   logic [9:0]  subCntQ;
   mtcr_word_t  nCntQ;
   assign sampleTick = kCntQ == 16'(KDiv - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         kCntQ <= 16'h0000;
      end else begin
         kCntQ <= sampleTick ? 16'h0000 : kCntQ + 16'h0001;
      end
   end

   // N below two is illegal; the counter then closes a cycle every 1024 samples
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         subCntQ   <= 10'h000;
         nCntQ     <= 24'h000000;
         cycleTick <= 1'b0;
      end else begin
         cycleTick <= 1'b0;
         if (sampleTick) begin
            subCntQ <= subCntQ + 10'h001;
            if (subCntQ == 10'(SamplesPerUnit - 1)) begin
               // Counter limit is read live, so a new N takes effect this cycle; see [R04]
               if (nCntQ + 24'h000001 >= cycleCountQ) begin // see [R05]
                  nCntQ     <= 24'h000000;
                  cycleTick <= 1'b1;
               end else begin
                  nCntQ <= nCntQ + 24'h000001;
               end
            end
         end
      end
   end

   // Tamper: magnitude of difference against threshold magnitude
   logic signed [24:0] diff;
   // Threshold is signed; its magnitude is the permitted difference
   logic [24:0]        diffAbs;
   logic [24:0]        thrAbs;
   logic               tamperNow;
   always_comb begin
      diff    = $signed({meas.firstActive[23], meas.firstActive}) - $signed({meas.secondActive[23], meas.secondActive});
      diffAbs = diff[24] ? 25'(-diff) : 25'(diff);
      thrAbs  = tamperQ[23] ? 25'(-$signed({tamperQ[23], tamperQ})) : {1'b0, tamperQ};
      tamperNow = diffAbs >= thrAbs; // see [R01]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tamperActive <= 1'b0;
      end else if (meas.resultValid) begin
         tamperActive <= tamperNow; // see [R01]
      end
   end

   // Reactive results are only latched here, never written by software
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         react1Q <= 24'h000000;
         react2Q <= 24'h000000;
      end else if (meas.resultValid) begin
         react1Q <= meas.reactiveFirst;  // see [R07]
         react2Q <= meas.reactiveSecond; // see [R07]
      end
   end

   // Under tamper the larger power is passed on; equal powers keep the first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulsePower <= 24'h000000;
      end else if (meas.resultValid) begin
         if (tamperNow && $signed(meas.secondActive) > $signed(meas.firstActive)) begin
            pulsePower <= meas.secondActive; // see [R02]
         end else begin
            pulsePower <= meas.firstActive;
         end
      end
   end

   // Temperature: (raw + offset) * gain, gain has 17 fraction bits; see [R09] [R10]
   logic signed [24:0] tSum;
   logic signed [49:0] tProd;
   always_comb begin
      tSum  = $signed({meas.tempRaw[23], meas.tempRaw}) + $signed({tempOffsetQ[23], tempOffsetQ});
      tProd = 50'(tSum * $signed({1'b0, tempGainQ}));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tempResult <= 24'h000000;
      end else if (meas.resultValid) begin
         tempResult <= tProd[40:17]; // see [R09]
      end
   end

   // Interrupts: set wins over write-one-to-clear, so an event in the clear cycle is kept
   assign irqEvent = {meas.resultValid && tamperNow, cycleTick};
   assign irqClear = wrSts ? wDataQ[IrqW-1:0] : '0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqStatusQ <= '0;
      end else begin
         irqStatusQ <= (irqStatusQ & ~irqClear) | irqEvent;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqMaskQ <= '0;
      end else if (wrMsk) begin
         irqMaskQ <= wDataQ[IrqW-1:0];
      end
   end

   // Level output lags the status by one clock so that it comes from a flip-flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatusQ & irqMaskQ);
      end
   end

   // Read channel: data captured at the address handshake and held until taken
   logic [7:0]  rdIdx;
   logic [31:0] rdData;
   logic        rdHit;
   assign rdIdx = {2'h0, sAxiAraddr[7:2]};
   always_comb begin
      rdHit  = 1'b1;
      rdData = 32'h0000_0000;
      case (rdIdx)
         IdxTempGain:   rdData = {8'h00, tempGainQ};
         IdxTempOffset: rdData = {8'h00, tempOffsetQ};
         IdxTamper:     rdData = {8'h00, tamperQ};
         IdxCycleCount: rdData = {8'h00, cycleCountQ};
         IdxReactive1:  rdData = {8'h00, react1Q};
         IdxReactive2:  rdData = {8'h00, react2Q};
         IdxIrqStatus:  rdData = {30'h0, irqStatusQ};
         IdxIrqMask:    rdData = {30'h0, irqMaskQ};
         default:       rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sAxiArready <= 1'b0;
         sAxiRvalid  <= 1'b0;
         sAxiRdata   <= 32'h0000_0000;
         sAxiRresp   <= RespOkay;
      end else begin
         sAxiArready <= !sAxiRvalid && !(sAxiArvalid && sAxiArready);
         if (sAxiArvalid && sAxiArready) begin
            sAxiRvalid <= 1'b1;
            sAxiRdata  <= rdData;
            sAxiRresp  <= rdHit ? RespOkay : RespSlvErr;
         end else if (sAxiRready) begin
            sAxiRvalid <= 1'b0;
         end
      end
   end
endmodule : mtcr_regs
`default_nettype wire

/* bench/mtcr_regs_props.sv */
// Checker for the register bank ports
`default_nettype none
module mtcr_regs_props (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 sAxiArvalid,
   input wire logic                 sAxiArready,
   input wire logic                 sAxiRvalid,
   input wire logic                 sAxiRready,
   input wire logic [31:0]          sAxiRdata,
   input wire logic                 sAxiBvalid,
   input wire logic                 sAxiBready,
   input wire logic [1:0]           sAxiBresp,
   input wire mtcr_pkg::mtcr_meas_s meas,
   input wire mtcr_pkg::mtcr_word_t pulsePower,
   input wire logic                 tamperActive,
   input wire logic                 cycleTick
);
   timeunit 1ns;
   timeprecision 1ps;
   import mtcr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_TAMPER_EQUAL: assert property (meas.resultValid && meas.firstActive == meas.secondActive |=> !tamperActive)
      else $error("tamper flagged with equal powers");
   AST_TAMPER_LARGER: assert property (meas.resultValid ##1 tamperActive |-> pulsePower ==
      (($signed($past(meas.firstActive)) >= $signed($past(meas.secondActive))) ? $past(meas.firstActive)
      : $past(meas.secondActive))) else $error("tamper did not pick the larger power");
   AST_TICK_SPACED: assert property (cycleTick |=> !cycleTick [*8])
      else $error("cycle ticks too close");
   AST_B_HOLD: assert property (sAxiBvalid && !sAxiBready |=> sAxiBvalid && $stable(sAxiBresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (sAxiRvalid && !sAxiRready |=> sAxiRvalid && $stable(sAxiRdata))
      else $error("read data dropped early");
   AST_R_TOP_ZERO: assert property (sAxiRvalid |-> sAxiRdata[31:24] == 8'h00)
      else $error("read data above bit 23 not zero");
   AST_R_ANSWER: assert property (sAxiArvalid && sAxiArready |=> sAxiRvalid)
      else $error("read answer late");
   AST_AR_BLOCK: assert property (sAxiRvalid |-> !sAxiArready)
      else $error("address taken while read pending");
   COV_TAMPER: cover property ($rose(tamperActive));
   COV_TICK: cover property (cycleTick);
   COV_WRITE: cover property (sAxiBvalid && sAxiBready);
endmodule : mtcr_regs_props
bind mtcr_regs mtcr_regs_props u_props (.clk(clk), .rst(rst), .sAxiArvalid(sAxiArvalid), .sAxiArready(sAxiArready),
   .sAxiRvalid(sAxiRvalid), .sAxiRready(sAxiRready), .sAxiRdata(sAxiRdata), .sAxiBvalid(sAxiBvalid),
   .sAxiBready(sAxiBready), .sAxiBresp(sAxiBresp), .meas(meas), .pulsePower(pulsePower),
   .tamperActive(tamperActive), .cycleTick(cycleTick));
`default_nettype wire

/* bench/mtcr_meas_src.sv */
// Measurement engine model feeding result words
`default_nettype none
module mtcr_meas_src (
   input wire logic             clk,
   output mtcr_pkg::mtcr_meas_s meas
);
   timeunit 1ns;
   timeprecision 1ps;
   import mtcr_pkg::*;
   initial meas = '0;
   // Words are only valid with the pulse, so they are scrambled afterwards
   task automatic give(input mtcr_word_t p1, input mtcr_word_t p2, input mtcr_word_t q, input mtcr_word_t t);
      @(posedge clk);
      meas <= '{p1, p2, q, ~q, t, 1'b1};
      @(posedge clk);
      meas <= '{~p1, ~p2, ~q, q, ~t, 1'b0};
   endtask : give
endmodule : mtcr_meas_src
`default_nettype wire

/* bench/test_mtcr_regs.sv */
// Testbench for the register bank
`default_nettype none
module test_mtcr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import mtcr_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic        awReady, wReady, bValid, arReady, rValid, tamp, tick, irq;
   logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
   logic [31:0] wData = 32'h0, rData;
   logic [1:0]  bResp, rResp;
   mtcr_meas_s  meas;
   mtcr_word_t  pulse, temp;
   int          n_fail = 0, num_checks = 0;
   always #4 clk = ~clk;
   mtcr_meas_src src (.clk(clk), .meas(meas));
   mtcr_regs dut (.clk(clk), .rst(rst), .sAxiAwaddr(awAddr), .sAxiAwvalid(awValid), .sAxiAwready(awReady),
      .sAxiWdata(wData), .sAxiWstrb(4'hf), .sAxiWvalid(wValid), .sAxiWready(wReady), .sAxiBresp(bResp),
      .sAxiBvalid(bValid), .sAxiBready(bReady), .sAxiAraddr(arAddr), .sAxiArvalid(arValid), .sAxiArready(arReady),
      .sAxiRdata(rData), .sAxiRresp(rResp), .sAxiRvalid(rValid), .sAxiRready(rReady), .meas(meas),
      .pulsePower(pulse), .tempResult(temp), .tamperActive(tamp), .cycleTick(tick), .irq(irq));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic hang;
      n_fail++;
      $display("mismatch wait exp done got timeout");
      wrap_up();
   endtask : hang
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Bready is raised with the request; the slave may answer on any of the next 64 edges
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
         if (bValid) break;
      end
      bReady <= 1'b0;
      if (i == 64) hang();
      chk("bresp", {30'h0, er}, {30'h0, bResp});
   endtask : axw
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int i;
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (arReady) arValid <= 1'b0;
         if (rValid) break;
      end
      rReady <= 1'b0;
      if (i == 64) hang();
      chk("rresp", {30'h0, er}, {30'h0, rResp});
      if (er == RespOkay) chk("rdata", e, rData);
   endtask : rdc
   task automatic t_reset_vals;
      rdc(8'h08, 32'h0034e2e7, RespOkay);
      rdc(8'h0c, 32'h00f38701, RespOkay);
      rdc(8'h48, 32'h00828f5c, RespOkay);
      rdc(8'h4c, 32'h00000fa0, RespOkay);
   endtask : t_reset_vals
   task automatic t_access;
      axw(8'h48, 32'hff123456, RespOkay);
      rdc(8'h48, 32'h00123456, RespOkay);
      axw(8'h48, 32'h00828f5c, RespOkay);
      src.give(24'h0, 24'h0, 24'h00aaaa, 24'h0);
      axw(8'h50, 32'h00123456, RespOkay);
      rdc(8'h50, 32'h0000aaaa, RespOkay);
      rdc(8'h54, 32'h00ff5555, RespOkay);
      axw(8'hfc, 32'h1, RespSlvErr);
      rdc(8'hfc, 32'h0, RespSlvErr);
   endtask : t_access
   // Threshold magnitude at reset is 0x7d70a4; cases sit on both sides of it
   task automatic t_tamper;
      mtcr_word_t p1[4] = '{24'h100000, 24'h000000, 24'h000001, 24'h7f0000};
      mtcr_word_t p2[4] = '{24'h100000, 24'h7d70a4, 24'h7d70a4, 24'h010000};
      logic       et[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
      mtcr_word_t ep[4] = '{24'h100000, 24'h7d70a4, 24'h000001, 24'h7f0000};
      for (int k = 0; k < 4; k++) begin
         src.give(p1[k], p2[k], 24'h0, 24'h0);
         #1;
         chk("tamper", {31'h0, et[k]}, {31'h0, tamp});
         chk("pulse", {8'h0, ep[k]}, {8'h0, pulse});
      end
   endtask : t_tamper
   task automatic t_temp;
      axw(8'h08, 32'h00020000, RespOkay);
      axw(8'h0c, 32'h0, RespOkay);
      src.give(24'h0, 24'h0, 24'h0, 24'h001234);
      #1;
      chk("temp", 32'h00001234, {8'h0, temp});
      axw(8'h0c, 32'h00000010, RespOkay);
      src.give(24'h0, 24'h0, 24'h0, 24'h001234);
      #1;
      chk("temp", 32'h00001244, {8'h0, temp});
   endtask : t_temp
   task automatic wait_tick(output int n);
      for (n = 0; n < 10000; n++) begin
         @(posedge clk);
         if (tick) break;
      end
      if (n == 10000) hang();
   endtask : wait_tick
   task automatic t_cycle;
      int n;
      axw(8'h84, 32'h0, RespOkay);
      axw(8'h4c, 32'h2, RespOkay);
      rdc(8'h4c, 32'h2, RespOkay);
      wait_tick(n);
      axw(8'h80, 32'h3, RespOkay);
      // Align to a tick first, since the bus calls above use part of a cycle
      wait_tick(n);
      wait_tick(n);
      chk("period", 32'd2048, n + 1);
      chk("irq masked", 32'h0, {31'h0, irq});
      rdc(8'h80, 32'h1, RespOkay);
      axw(8'h84, 32'h1, RespOkay);
      @(posedge clk);
      #1;
      chk("irq", 32'h1, {31'h0, irq});
      axw(8'h80, 32'h1, RespOkay);
      @(posedge clk);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask : t_cycle
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset_vals();
      t_access();
      t_tamper();
      t_temp();
      t_cycle();
      wrap_up();
   end
endmodule : test_mtcr_regs
`default_nettype wire
